// ### hw/sbam_addr_split.sv
// Combinational split of a host address into bank, row and column fields.
// Assumes the caller registers the outputs; no state is held here.
`timescale 1ns/1ps
module sbam_addr_split (
    input  wire logic [1:0]                        dev_in,
    input  wire logic                              col_phase_in,
    input  wire logic [sbam_pkg::HOST_ADDR_W-1:0]  addr_in,
    output logic      [sbam_pkg::MA_W-1:0]         ma_out,
    output logic                                   ba0_out,
    output logic                                   ba1_out
);
    // ------------------------------------------------------------------
    // Field selection per device type
    // ------------------------------------------------------------------
    wire logic [12:0] row_16m = {2'b00, addr_in[22:12]};
    wire logic [12:0] row_2b  = addr_in[24:12];
    wire logic [12:0] row_4b  = {1'b0, addr_in[24:13]};
    wire logic [12:0] col_16m = {3'b000, addr_in[24:23], addr_in[10:3]};
    wire logic [12:0] col_64m = {3'b000, addr_in[26:25], addr_in[10:3]};
    wire logic        is_16m  = (dev_in == 2'(sbam_pkg::SBAM_DEV_16M_2B));
    wire logic        is_4b   = (dev_in == 2'(sbam_pkg::SBAM_DEV_64M_4B));
    wire logic [12:0] row_sel = is_16m ? row_16m : (is_4b ? row_4b : row_2b);
    wire logic [12:0] col_sel = is_16m ? col_16m : col_64m;

    assign ma_out  = col_phase_in ? col_sel : row_sel;  // RULE8 RULE9 RULE10
    assign ba0_out = addr_in[11];                        // RULE8 RULE9 RULE10
    assign ba1_out = is_4b & addr_in[12];                // RULE10

endmodule : sbam_addr_split

// ### hw/sbam_mapper.sv
// SDRAM bank address mapper: drives bank chip selects, bank selects and
// multiplexed address pins for 16, 64 and 128 Mbit SDRAM parts.
// Assumes all inputs are synchronous to ref_clk_in and held stable for the
// row and column phases by the command sequencer outside this block.
//
// Notes on behaviour
// (RULE1) Every bank is one 64-bit data path, so host bits 2..0 never reach the pins.
// (RULE2) Total memory is at most 128 MBytes; addresses beyond it are flagged and not issued.
// (RULE3) With 16Mbit parts four separate bank chip selects are driven.
// (RULE4) With 64Mbit or 128Mbit parts only two bank chip selects are driven.
// (RULE5) For larger parts the third select pin carries address 11 and the fourth carries address 12 or bank bit one.
// (RULE6) Graphics memory starts at address zero of bank 0, which must be populated.
// (RULE7) Host memory starts right above graphics memory and runs to the top of populated memory.
// (RULE8) 16Mbit two-bank parts use A11 as bank select, row A22..A12, column 0,A24,A23,A10..A3.
// (RULE9) Large two-bank parts use A11 as bank select, row A24..A12, column 0,0,0,A26,A25,A10..A3.
// (RULE10) Large four-bank parts use A11 and A12 as bank selects, row A24..A13, column 0,0,A26,A25,A10..A3.
`timescale 1ns/1ps
module sbam_mapper (
    input  wire logic                              ref_clk_in,
    input  wire logic                              rst_n_in,
    input  wire logic [1:0]                        dev_type_in,
    input  wire logic [27:0]                       bank_size_in,
    input  wire logic [3:0]                        bank_present_in,
    input  wire logic [27:0]                       gfx_size_in,
    input  wire logic                              req_valid_in,
    input  wire logic                              req_gfx_in,
    input  wire logic                              col_phase_in,
    input  wire logic [sbam_pkg::HOST_ADDR_W-1:0]  req_addr_in,
    output logic      [10:0]                       memory_address_pins_out,
    output logic                                   bank_select_two_n_out,
    output logic                                   bank_select_three_n_out,
    output logic      [1:0]                        bank_cs_n_out,
    output logic                                   bank_address_bit_zero_out,
    output logic                                   bank_address_bit_one_out,
    output logic                                   addr_error_out,
    output logic                                   config_error_out
);
    // ------------------------------------------------------------------
    // Address translation: graphics from 0, host above graphics
    // ------------------------------------------------------------------
    wire logic [27:0] req_ext  = {1'b0, req_addr_in};
    // Host offsets that carry past 28 bits are refused rather than wrapped to low memory
    wire logic [28:0] phys_sum = 29'(req_ext) + 29'(gfx_size_in);
    wire logic [27:0] phys     = req_gfx_in ? req_ext                              // RULE6
                                            : phys_sum[27:0];                      // RULE7
    wire logic [27:0] populated;
    wire logic        is_16m   = (dev_type_in == 2'(sbam_pkg::SBAM_DEV_16M_2B));
    wire logic [2:0]  nbanks   = is_16m ? 3'h4 : 3'h2;                             // RULE3 RULE4
    wire logic [3:0]  usable   = is_16m ? bank_present_in                          // RULE3
                                        : {2'b00, bank_present_in[1:0]};           // RULE4
    wire logic [2:0]  pop_cnt  = 3'(usable[0]) + 3'(usable[1])
                               + 3'(usable[2]) + 3'(usable[3]);
    wire logic [30:0] pop_wide = 31'(pop_cnt) * 31'(bank_size_in);
    wire logic [30:0] cap_lim  = (pop_wide > 31'(sbam_pkg::MAX_CAPACITY))
                               ? 31'(sbam_pkg::MAX_CAPACITY) : pop_wide;           // RULE2
    assign populated = 28'(cap_lim);
    // Host region ends at top of populated memory; graphics must fit in it too
    wire logic        out_range = (phys >= populated)                              // RULE7
                                | (req_gfx_in & (req_ext >= gfx_size_in))
                                | (~req_gfx_in & phys_sum[28]);
    wire logic        cfg_bad   = ~bank_present_in[0]                              // RULE6
                                | (dev_type_in == 2'h3)
                                | (bank_size_in == 28'h0000000);

    // ------------------------------------------------------------------
    // Bank decode: banks are packed from bank 0 upward
    // ------------------------------------------------------------------
    logic [1:0] bank_idx;
    logic [27:0] in_bank;
    always_comb begin
        bank_idx = 2'h0;
        in_bank  = phys;
        if (bank_size_in != 28'h0000000) begin
            // Bank 2 and 3 bounds compared at 30 bits so that large bank sizes cannot wrap
            if (30'(phys) >= 30'(bank_size_in) * 30'h3 && nbanks == 3'h4) begin
                bank_idx = 2'h3;
                in_bank  = 28'(phys - 28'(3 * bank_size_in));
            end else if (30'(phys) >= 30'(bank_size_in) * 30'h2 && nbanks == 3'h4) begin
                bank_idx = 2'h2;
                in_bank  = 28'(phys - 28'(2 * bank_size_in));
            end else if (phys >= bank_size_in) begin
                bank_idx = 2'h1;
                in_bank  = 28'(phys - bank_size_in);
            end
        end
    end
    // Byte lanes inside the 64-bit word are handled by data masks, not address
    wire logic [26:0] bank_addr = {in_bank[26:sbam_pkg::BYTE_LANE_BITS],
                                   3'b000};                                        // RULE1
    wire logic        req_ok    = req_valid_in & ~out_range & ~cfg_bad
                                & usable[bank_idx];

    // ------------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------------
    wire logic [12:0] ma_map;
    wire logic        ba0_map;
    wire logic        ba1_map;
    sbam_addr_split u_split (
        .dev_in       (dev_type_in),
        .col_phase_in (col_phase_in),
        .addr_in      (bank_addr),
        .ma_out       (ma_map),
        .ba0_out      (ba0_map),
        .ba1_out      (ba1_map)
    );

    // ------------------------------------------------------------------
    // Pin multiplexing of the two upper select pins
    // ------------------------------------------------------------------
    wire logic [3:0] cs_dec   = ~(4'h1 << bank_idx);
    wire logic [3:0] cs_n_nx  = req_ok ? cs_dec : sbam_pkg::CS_N_RESET;
    wire logic       is_4b    = (dev_type_in == 2'(sbam_pkg::SBAM_DEV_64M_4B));
    wire logic       pin2_nx  = is_16m ? cs_n_nx[2] : ma_map[11];                  // RULE3 RULE5
    wire logic       pin3_nx  = is_16m ? cs_n_nx[3]
                              : (is_4b ? ba1_map : ma_map[12]);                    // RULE5

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            memory_address_pins_out   <= sbam_pkg::MA_RESET[10:0];
            bank_select_two_n_out     <= 1'b1;
            bank_select_three_n_out   <= 1'b1;
            bank_cs_n_out             <= 2'h3;
            bank_address_bit_zero_out <= 1'b0;
            bank_address_bit_one_out  <= 1'b0;
            addr_error_out            <= 1'b0;
            config_error_out          <= 1'b0;
        end else begin
            memory_address_pins_out   <= ma_map[10:0];                             // RULE8 RULE9
            bank_select_two_n_out     <= pin2_nx;                                  // RULE5
            bank_select_three_n_out   <= pin3_nx;                                  // RULE5
            bank_cs_n_out             <= cs_n_nx[1:0];                             // RULE4
            bank_address_bit_zero_out <= ba0_map;
            bank_address_bit_one_out  <= ba1_map;                                  // RULE10
            addr_error_out            <= req_valid_in & ~req_ok;                   // RULE2
            config_error_out          <= cfg_bad;                                  // RULE6
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_COL_LOW_ZERO: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE8
        col_phase_in |=> memory_address_pins_out[10] == 1'b0)
        else $error("column phase pin 10 not zero");
    AST_BA0_A11: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE8
        1'b1 |=> bank_address_bit_zero_out == $past(bank_addr[11]))
        else $error("bank select zero does not follow address bit 11");
    AST_LARGE_TWO_CS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE4
        (!is_16m && cs_n_nx[3:2] != 2'h3) |-> 1'b0)
        else $error("upper chip select decoded for large parts");
    AST_PIN3_BA1: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE5
        is_4b |=> bank_select_three_n_out == $past(bank_addr[12]))
        else $error("fourth select pin not bank bit one");
    AST_PIN2_A11: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE5
        (!is_16m && !col_phase_in) |=> bank_select_two_n_out == $past(ma_map[11]))
        else $error("third select pin not address 11");
    AST_CAP_LIMIT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE2
        (req_valid_in && phys >= 28'(sbam_pkg::MAX_CAPACITY)) |=> addr_error_out)
        else $error("access above capacity not flagged");
    AST_BANK0_REQ: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE6
        !bank_present_in[0] |=> config_error_out && bank_cs_n_out == 2'h3)
        else $error("missing bank 0 not refused");
    AST_GFX_BANK0: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE6
        (req_valid_in && req_gfx_in && req_addr_in == 27'h0 && !cfg_bad
            && gfx_size_in != 28'h0000000)
            |=> bank_cs_n_out[0] == 1'b0)
        else $error("graphics base not in bank 0");
    AST_HOST_ABOVE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE7
        (req_valid_in && !req_gfx_in) |-> phys >= gfx_size_in || phys < req_ext)
        else $error("host access below graphics top");
    AST_ROW_16M: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE8
        (is_16m && !col_phase_in) |=> memory_address_pins_out == $past(bank_addr[22:12]))
        else $error("16Mbit row address wrong");
    AST_COL_4B: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE10
        (is_4b && col_phase_in) |=> memory_address_pins_out[9:8] == $past(bank_addr[26:25]))
        else $error("four bank column upper bits wrong");
    AST_ROW_2B: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE9
        (dev_type_in == 2'h1 && !col_phase_in)
            |=> memory_address_pins_out == $past(bank_addr[22:12]))
        else $error("two bank row address wrong");

    // ------------------------------------------------------------------
    // Checks on pin sharing, refusal and address fields
    // ------------------------------------------------------------------
    // At most one rank may see its select low, or two ranks would drive the data bus
    AST_ONE_RANK_16M: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE3
        is_16m |=> $countones(~{bank_select_three_n_out, bank_select_two_n_out,
                                bank_cs_n_out}) <= 1)
        else $error("more than one rank selected");
    AST_REFUSE_NO_CS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE2
        (req_valid_in && !req_ok) |=> addr_error_out && bank_cs_n_out == 2'h3)
        else $error("refused access still selected a rank");
    AST_IDLE_NO_CS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE2
        !req_valid_in |=> !addr_error_out && bank_cs_n_out == 2'h3)
        else $error("rank selected without a request");
    AST_CFG_REFUSE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE6
        (req_valid_in && cfg_bad) |=> addr_error_out && config_error_out)
        else $error("access under bad configuration not refused");
    AST_BA1_TWO_BANK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE9
        !is_4b |=> !bank_address_bit_one_out)
        else $error("bank bit one driven for a two bank part");
    AST_COL_16M: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE8
        (is_16m && col_phase_in) |=> memory_address_pins_out
            == {1'b0, $past(bank_addr[24:23]), $past(bank_addr[10:3])})
        else $error("16Mbit column address wrong");
    AST_ROW_4B: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE10
        (is_4b && !col_phase_in) |=> memory_address_pins_out == $past(bank_addr[23:13]))
        else $error("four bank row address wrong");
    AST_PIN3_A12: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE5
        (dev_type_in == 2'h1 && !col_phase_in)
            |=> bank_select_three_n_out == $past(bank_addr[24]))
        else $error("fourth select pin not address 12");
    AST_COL_2B_UPPER: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE9
        (dev_type_in == 2'h1 && col_phase_in)
            |=> !bank_select_two_n_out && !bank_select_three_n_out)
        else $error("two bank column upper address not zero");
    // Taken from the undivided in-bank offset, so a lost byte-lane shift shows here
    AST_COL_WORD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE1
        col_phase_in |=> memory_address_pins_out[7:0] == $past(in_bank[10:3]))
        else $error("column word address wrong");
    AST_HOST_BASE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE7
        (req_valid_in && !req_gfx_in && req_addr_in == 27'h0000000 && !cfg_bad
            && gfx_size_in < bank_size_in && gfx_size_in < sbam_pkg::MAX_CAPACITY)
            |=> bank_cs_n_out[0] == 1'b0 && !addr_error_out)
        else $error("host base not right above graphics");

endmodule : sbam_mapper

// ### hw/sbam_pkg.sv
// Constants for the SDRAM bank address mapper.
// Assumes host byte addresses up to 27 bits wide and a 64-bit memory data path.
package sbam_pkg;

    // ------------------------------------------------------------------
    // Widths and capacity
    // ------------------------------------------------------------------
    localparam int          HOST_ADDR_W      = 27;
    localparam int          MA_W             = 13;
    localparam int          BANK_SEL_W       = 2;
    localparam int          DATA_PATH_BITS   = 64;
    localparam int          BYTE_LANE_BITS   = 3;
    localparam int          NUM_CS           = 4;
    localparam logic [27:0] MAX_CAPACITY     = 28'h8000000;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [MA_W-1:0]        MA_RESET   = 13'h0000;
    localparam logic [NUM_CS-1:0]      CS_N_RESET = 4'hf;
    localparam logic [HOST_ADDR_W-1:0] ADDR_RESET = 27'h0000000;

    // ------------------------------------------------------------------
    // Device types and address phases
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SBAM_DEV_16M_2B,
        SBAM_DEV_64M_2B,
        SBAM_DEV_64M_4B
    } sbam_dev_type;

    typedef enum logic {
        SBAM_PHASE_ROW,
        SBAM_PHASE_COL
    } sbam_phase_type;

endpackage : sbam_pkg

// ### sim/sbam_sdram_model.sv
// Behavioural model of the SDRAM ranks on the far side of the mapper.
// Assumes the rank selects are active low and that the part type is known to the board.
`timescale 1ns/1ps
module sbam_sdram_model (
    input  wire logic [1:0] dev_type_in,
    input  wire logic [1:0] bank_cs_n_in,
    input  wire logic       bank_select_two_n_in,
    input  wire logic       bank_select_three_n_in,
    output logic      [2:0] ranks_selected_out
);
    // ------------------------------------------------------------------
    // Rank decode
    // ------------------------------------------------------------------
    // Large parts reuse the upper two selects as address lines, so only two ranks answer
    always_comb begin
        ranks_selected_out = 3'(!bank_cs_n_in[0]) + 3'(!bank_cs_n_in[1]);
        if (dev_type_in == 2'h0) begin
            ranks_selected_out = ranks_selected_out + 3'(!bank_select_two_n_in)
                               + 3'(!bank_select_three_n_in);
        end
    end
endmodule : sbam_sdram_model

// ### sim/testbench.sv
// Self-checking bench for the SDRAM bank address mapper.
// Assumes outputs follow the sampled inputs by one clock and the rank model beside it.
`timescale 1ns/1ps
module testbench;
    logic        ref_clk_in, rst_n_in, req_valid_in, req_gfx_in, col_phase_in;
    logic [1:0]  dev_type_in;
    logic [3:0]  bank_present_in;
    logic [27:0] bank_size_in, gfx_size_in;
    logic [26:0] req_addr_in;
    logic [10:0] pins;
    logic        sel2_n, sel3_n, ba0, ba1, aerr, cerr;
    logic [1:0]  cs_n;
    logic [2:0]  ranks;
    logic [18:0] exp_q, mask_q;
    logic [31:0] r, r2;
    integer      seed = 32'he7ee;
    int          n_errors = 0;
    int          check_count = 0;

    sbam_mapper u_sbam_mapper (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .dev_type_in(dev_type_in), .bank_size_in(bank_size_in), .bank_present_in(bank_present_in),
        .gfx_size_in(gfx_size_in), .req_valid_in(req_valid_in), .req_gfx_in(req_gfx_in),
        .col_phase_in(col_phase_in), .req_addr_in(req_addr_in), .memory_address_pins_out(pins),
        .bank_select_two_n_out(sel2_n), .bank_select_three_n_out(sel3_n), .bank_cs_n_out(cs_n),
        .bank_address_bit_zero_out(ba0), .bank_address_bit_one_out(ba1),
        .addr_error_out(aerr), .config_error_out(cerr));
    sbam_sdram_model u_sbam_sdram_model (.dev_type_in(dev_type_in), .bank_cs_n_in(cs_n),
        .bank_select_two_n_in(sel2_n), .bank_select_three_n_in(sel3_n), .ranks_selected_out(ranks));

    // ------------------------------------------------------------------
    // Expected outputs and their care mask (set bits are compared) for the current inputs
    // ------------------------------------------------------------------
    function automatic void calc(output logic [18:0] e, output logic [18:0] m);
        logic [28:0] capw;
        logic [27:0] phys, cap, inb;
        logic [10:0] p;
        logic [3:0]  oh;
        logic        cfg_bad, bad, big, ok, s2, s3, c;
        int          cnt, bk;
        big = dev_type_in != 2'h0;
        c = col_phase_in;
        cfg_bad = !bank_present_in[0] || dev_type_in == 2'h3 || bank_size_in == 28'h0;
        cnt = 0;
        for (int i = 0; i < 4; i++)
            if (bank_present_in[i] && !(big && i > 1)) cnt++;
        capw = 29'(cnt) * {1'b0, bank_size_in};
        cap = (capw > 29'h8000000) ? 28'h8000000 : capw[27:0];
        phys = req_gfx_in ? {1'b0, req_addr_in} : {1'b0, req_addr_in} + gfx_size_in;
        bk = cfg_bad ? 0 : int'(phys / bank_size_in);
        inb = cfg_bad ? 28'h0 : phys % bank_size_in;
        bad = req_valid_in && (cfg_bad || (req_gfx_in && {1'b0, req_addr_in} >= gfx_size_in)
              || phys >= cap || !bank_present_in[bk[1:0]]);
        ok = req_valid_in && !bad;
        oh = ok ? 4'h1 << bk[1:0] : 4'h0;
        if (c)
            p = big ? {1'b0, inb[26], inb[25], inb[10:3]} : {1'b0, inb[24], inb[23], inb[10:3]};
        else
            p = (dev_type_in == 2'h2) ? inb[23:13] : inb[22:12];
        s2 = !oh[2];
        s3 = !oh[3];
        if (dev_type_in == 2'h1) begin
            s2 = !c && inb[23];
            s3 = !c && inb[24];
        end else if (big) begin
            s2 = !c && inb[24];
            s3 = inb[12];
        end
        e = {p, s2, s3, ~oh[1:0], inb[11], dev_type_in == 2'h2 && inb[12], bad, cfg_bad};
        m = {{11{ok}}, !big || ok, !big || ok, 2'h3, ok, ok, 2'h3};
    endfunction : calc

    task automatic compare(input logic [18:0] e, input logic [18:0] m);
        logic [18:0] got;
        logic [2:0]  exp_rk;
        got = {pins, sel2_n, sel3_n, cs_n, ba0, ba1, aerr, cerr};
        exp_rk = 3'((e[5:4] != 2'h3) || (dev_type_in == 2'h0 && e[7:6] != 2'h3));
        check_count++;
        if ((got & m) !== (e & m)) begin
            n_errors++;
            $display("CHECK FAILED mapper outputs expected %h seen %h", e & m, got & m);
        end
        check_count++;
        if (ranks !== exp_rk) begin
            n_errors++;
            $display("CHECK FAILED ranks selected expected %0d seen %0d", exp_rk, ranks);
        end
    endtask : compare

    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    // Generous bound: roughly three times the expected run
    initial begin
        #30000;
        n_errors++;
        give_verdict();
    end

    initial begin
        {rst_n_in, req_valid_in, req_gfx_in, col_phase_in, dev_type_in} = '0;
        {bank_present_in, bank_size_in, gfx_size_in, req_addr_in} = '0;
        repeat (5) @(posedge ref_clk_in);
        #1;
        compare({11'h0, 1'b1, 1'b1, 2'h3, 4'h0}, 19'h7ffff);
        rst_n_in = 1'b1;
        for (int k = 0; k < 450; k++) begin
            r = $random(seed);
            r2 = $random(seed);
            dev_type_in = (r[1:0] == 2'h3) ? 2'h0 : r[1:0];
            bank_size_in = (dev_type_in == 2'h0) ? 28'h2000000 : 28'h4000000;
            bank_present_in = (dev_type_in == 2'h0) ? (4'hf >> r[3:2]) : (r[2] ? 4'h3 : 4'h1);
            gfx_size_in = {6'h0, r[18:0], 3'h0};
            req_valid_in = r[22:20] != 3'h0;
            req_gfx_in = r[23];
            col_phase_in = r[24];
            req_addr_in = r2[31] ? r2[26:0] : {4'h0, r2[22:0]};
            case (r[28:25])
                4'h0: bank_present_in = 4'h5;
                4'h1: bank_present_in = 4'he;
                4'h2: dev_type_in = 2'h3;
                4'h3: bank_size_in = 28'h0;
                4'h4: {req_gfx_in, req_addr_in} = {1'b1, gfx_size_in[26:0] - 27'h8};
                4'h5: {req_gfx_in, req_addr_in} = {1'b1, gfx_size_in[26:0]};
                4'h6: {req_gfx_in, req_addr_in} = {1'b0, 27'(bank_size_in - gfx_size_in - 28'h8)};
                4'h7: {req_gfx_in, req_addr_in} = {1'b0, 27'(bank_size_in - gfx_size_in)};
                4'h8: if (dev_type_in != 2'h0) bank_size_in = 28'h8000000;
                4'h9: {req_gfx_in, req_addr_in} = {1'b0, 27'h0000000};
                4'ha: {req_gfx_in, req_addr_in} = {1'b1, 27'h0000000};
                default: ;
            endcase
            calc(exp_q, mask_q);
            @(posedge ref_clk_in);
            #1;
            compare(exp_q, mask_q);
        end
        give_verdict();
    end
endmodule : testbench
